/* File: bench/pll_loop_and_lock_config_tb.sv */
// Purpose: register and lock debounce tests for pllcfg_top
// Assumes: axi4-lite master with ready signals held high
// Notes: long debounce shortened to 200 cycles
`timescale 1ns/10ps
module pll_loop_and_lock_config_tb;
  logic aclk = 0, aresetn = 0;
  logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [3:0] s_axi_wstrb = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_val;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_bready = 1, s_axi_rready = 1;
  logic s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid;
  logic s_axi_rvalid, doubler_en, vco_filter_bypass, third_pole_skip;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic fine_lock_raw = 0, coarse_lock_raw = 0, vco_cal_done = 0;
  logic fine_lock_en, pll_lock, serial_out_pin;
  logic [2:0] pole_cap_select, third_pole_resistor, third_pole_capacitor;
  logic [2:0] lock_rc_select;
  logic [3:0] filter_resistor_select;
  logic [4:0] adr [4] = '{5'h00, 5'h04, 5'h08, 5'h0c};
  logic [31:0] rst [4] = '{32'h1, 32'h76, 32'h37, 32'h180};
  logic [31:0] msk [4] = '{32'h1, 32'hff, 32'hf7, 32'h3ff};
  int num_errors = 0, total_checks = 0;
  wire [31:0] outs = {12'h0, doubler_en, vco_filter_bypass, pole_cap_select,
    filter_resistor_select, third_pole_skip, third_pole_resistor,
    third_pole_capacitor, fine_lock_en, lock_rc_select};
  always #20 aclk = ~aclk;
  pllcfg_top #(.DEB_LONG(200)) u_pllcfg_top (.*);
  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk
  task automatic ticks(input int n);
    repeat (n) @(posedge aclk);
  endtask : ticks
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
    input logic [3:0] s);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_val = s_axi_rdata;
    resp = s_axi_rresp;
  endtask : rd
  task automatic deb(input logic [31:0] cfg, input int n);
    fine_lock_raw <= 1'b0;
    wr(4'hc, cfg, 4'h3);
    ticks(4);
    fine_lock_raw <= 1'b1;
    ticks(n - 6);
    chk("early lock", 0, pll_lock);
    ticks(12);
    chk("late lock", 1, pll_lock);
  endtask : deb
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  // ==========================================================
  // tests
  initial
  begin
    ticks(20);
    aresetn <= 1'b1;
    ticks(1);
    for (int i = 0; i < 4; i++)
    begin
      rd(adr[i]);
      chk("reset value", rst[i], rd_val);
      chk("rresp ok", 0, resp);
    end
    for (int p = 0; p < 2; p++)
    begin
      for (int i = 0; i < 4; i++)
      begin
        wr(adr[i], p ? 32'h0 : '1, 4'hf);
        rd(adr[i]);
        chk("reg", p ? 32'h0 : msk[i], rd_val);
      end
      chk("outputs", p ? 32'h0 : 32'hfffff, outs);
    end
    wr(4'h6, '1, 4'hf);
    chk("bresp", 2, resp);
    rd(4'h6);
    chk("rresp", 2, resp);
    chk("rdata", 0, rd_val);
    vco_cal_done <= 1'b1;
    deb(32'h100, 6);
    deb(32'h140, 570);
    deb(32'h180, 5700);
    deb(32'h1c0, 200);
    fine_lock_raw <= 1'b0;
    ticks(8);
    chk("real time", 0, pll_lock);
    fine_lock_raw <= 1'b1;
    ticks(100);
    fine_lock_raw <= 1'b0;
    ticks(1);
    fine_lock_raw <= 1'b1;
    ticks(190);
    chk("restart", 0, pll_lock);
    wr(4'hc, 32'h0, 4'h3);
    ticks(10);
    chk("coarse off", 0, pll_lock);
    coarse_lock_raw <= 1'b1;
    ticks(10);
    chk("coarse on", 1, pll_lock);
    rd(5'h10);
    chk("status", 3, rd_val);
    coarse_lock_raw <= 1'b0;
    wr(4'hc, 32'h120, 4'h3);
    ticks(10);
    fine_lock_raw <= 1'b0;
    ticks(10);
    chk("sticky", 1, pll_lock);
    chk("pin lock", 1, serial_out_pin);
    wr(4'hc, 32'h100, 4'h3);
    ticks(8);
    chk("unstick", 0, pll_lock);
    vco_cal_done <= 1'b0;
    fine_lock_raw <= 1'b1;
    ticks(10);
    chk("cal gate", 0, pll_lock);
    wr(4'hc, 32'h110, 4'h3);
    ticks(10);
    chk("cal run", 1, pll_lock);
    fine_lock_raw <= 1'b0;
    wr(4'hc, 32'h108, 4'h3);
    ticks(10);
    chk("forced", 1, pll_lock);
    vco_cal_done <= 1'b1;
    wr(4'hc, 32'h3c0, 4'h3);
    fine_lock_raw <= 1'b1;
    ticks(8);
    chk("pin raw", 1, serial_out_pin);
    chk("lock held", 0, pll_lock);
    complete_run();
  end
  initial
  begin
    ticks(30000);
    num_errors++;
    complete_run();
  end
endmodule : pll_loop_and_lock_config_tb

/* File: bench/pllcfg_checker.sv */
// Purpose: port level assertions for the pll config block
// Assumes: one clock, synchronous active low reset
// Notes: bound to every pllcfg_top instance
`timescale 1ns/10ps
module pllcfg_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // controls
  input wire logic doubler_en,
  input wire logic vco_filter_bypass,
  input wire logic [2:0] pole_cap_select,
  input wire logic [3:0] filter_resistor_select,
  input wire logic third_pole_skip,
  input wire logic [2:0] third_pole_resistor,
  input wire logic [2:0] third_pole_capacitor,
  input wire logic fine_lock_en,
  input wire logic [2:0] lock_rc_select,
  input wire logic pll_lock
);
  import pllcfg_pkg::*;
  logic [4:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  // ==========================================================
  // last write taken
  always_ff @(posedge aclk)
  begin
    if (s_axi_awvalid && s_axi_awready)
      wa <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready)
    begin
      wd <= s_axi_wdata;
      ws <= s_axi_wstrb;
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  filt_reset_a: assert property (
    $rose(aresetn) |-> doubler_en && !vco_filter_bypass &&
    pole_cap_select == 3'h7 && filter_resistor_select == 4'h6)
    else $error("filter controls not at reset value");
  lock_reset_a: assert property (
    $rose(aresetn) |-> !third_pole_skip && third_pole_resistor == 3'h3 &&
    third_pole_capacitor == 3'h7 && fine_lock_en && lock_rc_select == 3'h0
    && !pll_lock)
    else $error("lock controls not at reset value");
  write_resp_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:4] s_axi_bvalid)
    else $error("write response missing");
  read_resp_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  gen_write_a: assert property (
    $rose(s_axi_bvalid) && wa == PLLCFG_GENERAL_ADDR && ws[0]
    |-> ##[0:2] doubler_en == wd[0])
    else $error("doubler enable not updated");
  filt_write_a: assert property (
    $rose(s_axi_bvalid) && wa == PLLCFG_FILTER_ADDR && ws[0] |-> ##[0:2]
    {vco_filter_bypass, pole_cap_select, filter_resistor_select} == wd[7:0])
    else $error("loop filter controls not updated");
  third_write_a: assert property (
    $rose(s_axi_bvalid) && wa == PLLCFG_THIRD_ADDR && ws[0] |-> ##[0:2]
    {third_pole_skip, third_pole_resistor, third_pole_capacitor}
    == {wd[7:4], wd[2:0]})
    else $error("third pole controls not updated");
  lock_write_a: assert property (
    $rose(s_axi_bvalid) && wa == PLLCFG_LOCK_ADDR && ws[1:0] == 2'h3
    |-> ##[0:2] fine_lock_en == wd[8] && lock_rc_select == wd[2:0])
    else $error("lock controls not updated");
endmodule : pllcfg_checker

bind pllcfg_top pllcfg_checker u_pllcfg_checker (.*);

/* File: hdl/pllcfg_debounce.sv */
// Purpose: lock debounce and qualification for the pll lock detector
// Assumes: raw lock inputs synchronous to aclk
// Notes: long interval is a parameter so simulation may shorten it
`timescale 1ns/10ps
module pllcfg_debounce #(
  parameter int DEB_LONG = 57000
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic [1:0] timer_sel,
  input wire logic sticky,
  input wire logic cal_run,
  input wire logic force_lock,
  input wire logic fine_en,
  input wire logic cal_done,
  // raw detectors
  input wire logic fine_raw,
  input wire logic coarse_raw,
  // result
  output logic raw_sel,
  output logic lock
);
  import pllcfg_pkg::*;
  logic [PLLCFG_CNT_W-1:0] count;
  logic [PLLCFG_CNT_W-1:0] limit;
  logic raw;
  logic enabled;
  logic done;
  logic next_lock;
  assign raw = fine_en ? fine_raw : coarse_raw;
  assign enabled = cal_run | cal_done;
  assign limit = (timer_sel == 2'h0) ? '0 :
    (timer_sel == 2'h1) ? PLLCFG_CNT_W'(PLLCFG_DEB1) :
    (timer_sel == 2'h2) ? PLLCFG_CNT_W'(PLLCFG_DEB2) :
    PLLCFG_CNT_W'(DEB_LONG);
  assign done = raw && enabled && (count >= limit);
  assign next_lock = force_lock ? 1'b1 :
    (sticky && lock) ? 1'b1 : done;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count <= '0;
      lock <= 1'b0;
      raw_sel <= 1'b0;
    end
    else
    begin
      raw_sel <= raw;
      lock <= next_lock;
      if (!raw || !enabled)
        count <= '0;
      else if (count < limit)
        count <= count + 1'b1;
    end
  end
endmodule : pllcfg_debounce

/* File: hdl/pllcfg_pkg.sv */
// Purpose: constants for the pll loop and lock configuration block
// Assumes: axi4-lite register access, one 25 MHz clock
// Notes: offsets are local choices, one aligned word per register
package pllcfg_pkg;
  // ==========================================================
  // register map
  localparam logic [4:0] PLLCFG_GENERAL_ADDR = 5'h00;
  localparam logic [4:0] PLLCFG_FILTER_ADDR = 5'h04;
  localparam logic [4:0] PLLCFG_THIRD_ADDR = 5'h08;
  localparam logic [4:0] PLLCFG_LOCK_ADDR = 5'h0c;
  // ==========================================================
  // reset values
  localparam logic [7:0] PLLCFG_GENERAL_RST = 8'h01;
  localparam logic [7:0] PLLCFG_FILTER_RST = 8'h76;
  localparam logic [7:0] PLLCFG_THIRD_RST = 8'h37;
  localparam logic [15:0] PLLCFG_LOCK_RST = 16'h0180;
  // ==========================================================
  // writable bit masks (reserved bits read zero)
  localparam logic [7:0] PLLCFG_GENERAL_MASK = 8'h01;
  localparam logic [7:0] PLLCFG_FILTER_MASK = 8'hff;
  localparam logic [7:0] PLLCFG_THIRD_MASK = 8'hf7;
  localparam logic [15:0] PLLCFG_LOCK_MASK = 16'h03ff;
  // ==========================================================
  // field positions
  localparam int PLLCFG_DOUBLER_BIT = 0;
  localparam int PLLCFG_VCO_FILT_BIT = 7;
  localparam int PLLCFG_CAP_LSB = 4;
  localparam int PLLCFG_RES_LSB = 0;
  localparam int PLLCFG_SKIP_BIT = 7;
  localparam int PLLCFG_R3_LSB = 4;
  localparam int PLLCFG_C3_LSB = 0;
  localparam int PLLCFG_RAW_BIT = 9;
  localparam int PLLCFG_FINE_BIT = 8;
  localparam int PLLCFG_TIMER_LSB = 6;
  localparam int PLLCFG_STICKY_BIT = 5;
  localparam int PLLCFG_CALRUN_BIT = 4;
  localparam int PLLCFG_FORCE_BIT = 3;
  localparam int PLLCFG_RCSEL_LSB = 0;
  // status register: bit0 debounced lock, bit1 raw lock
  localparam logic [4:0] PLLCFG_STATUS_ADDR = 5'h10;
  // ==========================================================
  // debounce counts in system clock cycles
  localparam int PLLCFG_DEB1 = 570;
  localparam int PLLCFG_DEB2 = 5700;
  localparam int PLLCFG_DEB3 = 57000;
  localparam int PLLCFG_CNT_W = 16;
  // ==========================================================
  // axi responses
  localparam logic [1:0] PLLCFG_OKAY = 2'h0;
  localparam logic [1:0] PLLCFG_SLVERR = 2'h2;
endpackage : pllcfg_pkg

/* File: hdl/pllcfg_top.sv */
// Purpose: pll loop filter and lock detector configuration registers
// Assumes: axi4-lite master, 25 MHz aclk, synchronous active low reset
// Notes: analog settings leave as plain register outputs
//
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
module pllcfg_top #(
  parameter int DEB_LONG = pllcfg_pkg::PLLCFG_DEB3
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog lock detector inputs
  input wire logic fine_lock_raw,
  input wire logic coarse_lock_raw,
  input wire logic vco_cal_done,
  // analog controls
  output logic doubler_en,
  output logic vco_filter_bypass,
  output logic [2:0] pole_cap_select,
  output logic [3:0] filter_resistor_select,
  output logic third_pole_skip,
  output logic [2:0] third_pole_resistor,
  output logic [2:0] third_pole_capacitor,
  output logic fine_lock_en,
  output logic [2:0] lock_rc_select,
  // lock results
  output logic pll_lock,
  output logic serial_out_pin
);
  import pllcfg_pkg::*;
  // ==========================================================
  // registers
  logic [7:0] general_cfg;
  logic [7:0] filter_cfg;
  logic [7:0] third_cfg;
  logic [15:0] lock_cfg;
  logic [4:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic lock_db;
  logic lock_raw;
  // ==========================================================
  // write decode
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire wr_gen = aw_addr == PLLCFG_GENERAL_ADDR;
  wire wr_filt = aw_addr == PLLCFG_FILTER_ADDR;
  wire wr_third = aw_addr == PLLCFG_THIRD_ADDR;
  wire wr_lock = aw_addr == PLLCFG_LOCK_ADDR;
  wire wr_hit = wr_gen | wr_filt | wr_third | wr_lock;
  wire [15:0] lock_new = {w_strb[1] ? w_data[15:8] : lock_cfg[15:8],
    w_strb[0] ? w_data[7:0] : lock_cfg[7:0]};
  wire [15:0] next_lock_cfg = lock_new & PLLCFG_LOCK_MASK;
  // ==========================================================
  // read decode
  wire rd_gen = s_axi_araddr == PLLCFG_GENERAL_ADDR;
  wire rd_filt = s_axi_araddr == PLLCFG_FILTER_ADDR;
  wire rd_third = s_axi_araddr == PLLCFG_THIRD_ADDR;
  wire rd_lock = s_axi_araddr == PLLCFG_LOCK_ADDR;
  wire rd_stat = s_axi_araddr == PLLCFG_STATUS_ADDR;
  wire rd_hit = rd_gen | rd_filt | rd_third | rd_lock | rd_stat;
  wire [31:0] next_rdata = rd_gen ? {24'h0, general_cfg} :
    rd_filt ? {24'h0, filter_cfg} :
    rd_third ? {24'h0, third_cfg} :
    rd_lock ? {16'h0, lock_cfg} :
    rd_stat ? {30'h0, lock_raw, lock_db} : 32'h0;
  // ==========================================================
  // write channels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 5'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PLLCFG_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? PLLCFG_OKAY : PLLCFG_SLVERR;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // ==========================================================
  // configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      general_cfg <= PLLCFG_GENERAL_RST;
      filter_cfg <= PLLCFG_FILTER_RST;
      third_cfg <= PLLCFG_THIRD_RST;
      lock_cfg <= PLLCFG_LOCK_RST;
    end
    else if (do_write)
    begin
      if (wr_gen && w_strb[0])
        general_cfg <= w_data[7:0] & PLLCFG_GENERAL_MASK;
      if (wr_filt && w_strb[0])
        filter_cfg <= w_data[7:0] & PLLCFG_FILTER_MASK;
      if (wr_third && w_strb[0])
        third_cfg <= w_data[7:0] & PLLCFG_THIRD_MASK;
      if (wr_lock)
        lock_cfg <= next_lock_cfg;
    end
  end
  // ==========================================================
  // read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= PLLCFG_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= rd_hit ? PLLCFG_OKAY : PLLCFG_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
  // ==========================================================
  // analog control outputs, registered
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      doubler_en <= 1'b1;
      vco_filter_bypass <= 1'b0;
      pole_cap_select <= 3'h7;
      filter_resistor_select <= 4'h6;
      third_pole_skip <= 1'b0;
      third_pole_resistor <= 3'h3;
      third_pole_capacitor <= 3'h7;
      fine_lock_en <= 1'b1;
      lock_rc_select <= 3'h0;
    end
    else
    begin
      doubler_en <= general_cfg[PLLCFG_DOUBLER_BIT];
      vco_filter_bypass <= filter_cfg[PLLCFG_VCO_FILT_BIT];
      pole_cap_select <= filter_cfg[PLLCFG_CAP_LSB +: 3];
      filter_resistor_select <= filter_cfg[PLLCFG_RES_LSB +: 4];
      // software keeps this clear unless the divider is integer
      third_pole_skip <= third_cfg[PLLCFG_SKIP_BIT];
      third_pole_resistor <= third_cfg[PLLCFG_R3_LSB +: 3];
      third_pole_capacitor <= third_cfg[PLLCFG_C3_LSB +: 3];
      fine_lock_en <= lock_cfg[PLLCFG_FINE_BIT];
      lock_rc_select <= lock_cfg[PLLCFG_RCSEL_LSB +: 3];
    end
  end
  // ==========================================================
  // lock detector
  pllcfg_debounce #(
    .DEB_LONG(DEB_LONG)
  ) u_debounce (
    .aclk(aclk),
    .aresetn(aresetn),
    .timer_sel(lock_cfg[PLLCFG_TIMER_LSB +: 2]),
    .sticky(lock_cfg[PLLCFG_STICKY_BIT]),
    .cal_run(lock_cfg[PLLCFG_CALRUN_BIT]),
    .force_lock(lock_cfg[PLLCFG_FORCE_BIT]),
    .fine_en(lock_cfg[PLLCFG_FINE_BIT]),
    .cal_done(vco_cal_done),
    .fine_raw(fine_lock_raw),
    .coarse_raw(coarse_lock_raw),
    .raw_sel(lock_raw),
    .lock(lock_db)
  );
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pll_lock <= 1'b0;
      serial_out_pin <= 1'b0;
    end
    else
    begin
      pll_lock <= lock_db;
      serial_out_pin <= lock_cfg[PLLCFG_RAW_BIT] ?
        lock_raw : lock_db;
    end
  end
endmodule : pllcfg_top
